// [dfs_scan.sv]
`timescale 1ns/1ps
package dfs_pkg;
   // APB register map, byte addresses
   localparam logic [7:0] DFS_REG_CTRL   = 8'h00;
   localparam logic [7:0] DFS_REG_ADDR   = 8'h04;
   localparam logic [7:0] DFS_REG_DATA   = 8'h08;
   localparam logic [7:0] DFS_REG_STATUS = 8'h0c;
   localparam logic [7:0] DFS_REG_CMD    = 8'h10;
   localparam logic [7:0] DFS_REG_PRESC  = 8'h14;

   // Control register fields
   localparam int DFS_CTRL_RIGHT  = 0;
   localparam int DFS_CTRL_DISP16 = 1;
   localparam int DFS_CTRL_AUTO   = 2;
   localparam int DFS_CTRL_SPEC   = 3;
   localparam int DFS_CTRL_SENSOR = 4;

   // Command register fields, write-one pulses
   localparam int DFS_CMD_CLR_DISP = 0;
   localparam int DFS_CMD_CLR_FIFO = 1;
   localparam int DFS_CMD_CLR_ALL  = 2;

   // Status word fields
   localparam int DFS_ST_FULL  = 3;
   localparam int DFS_ST_UNDER = 4;
   localparam int DFS_ST_OVER  = 5;
   localparam int DFS_ST_SE    = 6;
   localparam int DFS_ST_UNAV  = 7;

   // Sizes and codes
   localparam logic [3:0] DFS_FIFO_FULL  = 4'h8;
   localparam logic [3:0] DFS_MASK16     = 4'hf;
   localparam logic [3:0] DFS_MASK8      = 4'h7;
   localparam logic [7:0] DFS_BLANK      = 8'h00;
   localparam logic [31:0] DFS_ZERO_WORD = 32'h0000_0000;

   // Timing
   localparam int DFS_CLK_PERIOD_NS = 40;
   localparam int DFS_CLEAR_NS      = 160_000;
   localparam int DFS_INT_CLK_NS    = 10_000;
   localparam int DFS_SCAN16_NS     = 10_300_000;
   localparam int DFS_CLEAR_CYC_I   = (DFS_CLEAR_NS + DFS_CLK_PERIOD_NS - 1) / DFS_CLK_PERIOD_NS;
   localparam int DFS_PRESC_I       = DFS_INT_CLK_NS / DFS_CLK_PERIOD_NS;
   localparam int DFS_DIGIT_TICKS_I = DFS_SCAN16_NS / (16 * DFS_INT_CLK_NS);
   localparam logic [11:0] DFS_CLEAR_CYC   = 12'(DFS_CLEAR_CYC_I);
   localparam logic [7:0]  DFS_PRESC_RESET = 8'(DFS_PRESC_I);
   localparam logic [6:0]  DFS_DIGIT_TICKS = 7'(DFS_DIGIT_TICKS_I);
endpackage

// Digit scan timing: prescaled internal tick, fixed time per digit
module dfs_scan
   import dfs_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       nrst_i,
   // Configuration
   input  wire logic [7:0] presc_i,
   input  wire logic       disp16_i,
   // Scan position
   output logic [3:0]      digit_o
);
   typedef struct packed {
      logic [7:0] presc_cnt;
      logic [6:0] tick_cnt;
      logic [3:0] digit;
   } dfs_scan_state_t;

   dfs_scan_state_t s;
   dfs_scan_state_t next_s;

   // Each digit gets the same on time, so eight digits scan twice as often
   always_comb begin
      next_s = s;
      if (s.presc_cnt + 8'h01 >= presc_i) begin // see R15
         next_s.presc_cnt = 8'h00;
         if (s.tick_cnt == DFS_DIGIT_TICKS - 7'h01) begin
            next_s.tick_cnt = 7'h00;
            next_s.digit    = (s.digit + 4'h1) & (disp16_i ? DFS_MASK16 : DFS_MASK8); // see R8
         end else begin
            next_s.tick_cnt = s.tick_cnt + 7'h01;
         end
      end else begin
         next_s.presc_cnt = s.presc_cnt + 8'h01;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign digit_o = s.digit;
endmodule // dfs_scan

// [dfs_display_fifo.sv]
// Overview of operation
// R1: Left entry maps RAM location to digit
// R2: Left entry wraps to leftmost after filling
// R3: Right entry shifts left, new char rightmost
// R4: Auto-increment advances write address by one
// R5: Without auto-increment, address stays put
// R6: Right entry increments like left entry
// R7: Host should start right entry at zero
// R8: Eight digits doubles each digit's duty
// R9: Status reports FIFO count and errors
// R10: Entry into full FIFO flags overrun
// R11: Reading empty FIFO flags underrun
// R12: Status shows display unavailable while clearing
// R13: Sensor mode status shows closure present
// R14: Special error mode shows error flag
// R15: Host programs prescaler for 10 us tick
// R16: Data writes go to display RAM address
// R17: Status returned on status port read
// R18: Clear refuses writes about 160 us, self-ends
// R19: Status layout count, full, under, over, S/E, busy
// R20: Write address wraps modulo display length
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module dfs_display_fifo
   import dfs_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Key entry and sensor side
   input  wire logic        key_valid_i,
   input  wire logic [7:0]  key_code_i,
   input  wire logic        multi_key_i,
   input  wire logic        sensor_closure_i,
   // Display drive
   output logic [3:0]       digit_o,
   output logic [7:0]       seg_o
);
   typedef struct packed {
      logic [15:0][7:0] ram;
      logic [3:0]       waddr;
      logic             right_entry;
      logic             disp16;
      logic             auto_increment_flag;
      logic             spec_err;
      logic             sensor_mode;
      logic [7:0][7:0]  fifo;
      logic [2:0]       rd_ptr;
      logic [2:0]       wr_ptr;
      logic [3:0]       count;
      logic             overrun;
      logic             underrun;
      logic             err_flag;
      logic             clearing;
      logic [11:0]      clr_cnt;
      logic [7:0]       presc;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      logic [3:0]       digit;
      logic [7:0]       seg;
   } dfs_state_t;

   dfs_state_t s;
   dfs_state_t next_s;
   logic       acc;
   logic       do_push;
   logic       do_pop;
   logic       fclr;
   logic       data_wr;
   logic [3:0] mask;
   logic [3:0] last;
   logic [7:0] status_w;
   logic       se_bit;
   logic [3:0] scan_digit;

   // All checks below run on the system clock and rest while reset is low
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   // Digit scan timing lives in its own small block
   dfs_scan u_scan (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .presc_i   (s.presc),
      .disp16_i  (s.disp16),
      .digit_o   (scan_digit)
   );

   // Display length and status word
   always_comb begin
      mask   = s.disp16 ? DFS_MASK16 : DFS_MASK8; // see R20
      last   = mask;                              // see R1
      se_bit = s.spec_err ? s.err_flag               // see R14
                          : (s.sensor_mode & sensor_closure_i); // see R13
      status_w                = '0;
      status_w[2:0]           = s.count[2:0];               // see R9
      status_w[DFS_ST_FULL]   = (s.count == DFS_FIFO_FULL); // see R19
      status_w[DFS_ST_UNDER]  = s.underrun;
      status_w[DFS_ST_OVER]   = s.overrun;
      status_w[DFS_ST_SE]     = se_bit;
      status_w[DFS_ST_UNAV]   = s.clearing;                 // see R12
   end

   // Next state: blanking countdown first, then bus access, hardware events last so a set beats a clear
   always_comb begin
      next_s         = s;
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      acc     = psel_i & penable_i & ~s.pready;
      do_push = 1'b0;
      do_pop  = 1'b0;
      fclr    = 1'b0;
      data_wr = acc & pwrite_i & (paddr_i == DFS_REG_DATA);

      // Blanking runs down on its own and frees the RAM again
      if (s.clearing) begin
         next_s.clr_cnt = s.clr_cnt - 12'h001;
         if (s.clr_cnt == 12'h001) begin
            next_s.clearing = 1'b0; // see R18
         end
      end

      if (acc) begin
         next_s.pready = 1'b1;
         next_s.prdata = DFS_ZERO_WORD;
         unique case (paddr_i)
            DFS_REG_CTRL: begin
               if (pwrite_i) begin
                  next_s.right_entry         = pwdata_i[DFS_CTRL_RIGHT];
                  next_s.disp16              = pwdata_i[DFS_CTRL_DISP16];
                  next_s.auto_increment_flag = pwdata_i[DFS_CTRL_AUTO];
                  next_s.spec_err            = pwdata_i[DFS_CTRL_SPEC];
                  next_s.sensor_mode         = pwdata_i[DFS_CTRL_SENSOR];
               end else begin
                  next_s.prdata[DFS_CTRL_RIGHT]  = s.right_entry;
                  next_s.prdata[DFS_CTRL_DISP16] = s.disp16;
                  next_s.prdata[DFS_CTRL_AUTO]   = s.auto_increment_flag;
                  next_s.prdata[DFS_CTRL_SPEC]   = s.spec_err;
                  next_s.prdata[DFS_CTRL_SENSOR] = s.sensor_mode;
               end
            end
            DFS_REG_ADDR: begin
               // Acts as the display command that sets the write address
               if (pwrite_i) begin
                  next_s.waddr = pwdata_i[3:0] & mask; // see R16
               end else begin
                  next_s.prdata[3:0] = s.waddr;
               end
            end
            DFS_REG_DATA: begin
               if (pwrite_i) begin
                  if (s.clearing) begin
                     next_s.pslverr = 1'b1; // see R18
                  end else begin
                     if (s.right_entry) begin
                        // Shift the visible digits left; leftmost is lost
                        for (int i = 0; i < 15; i++) begin
                           if (4'(i) < last) begin
                              next_s.ram[i] = s.ram[i + 1]; // see R3
                           end
                        end
                        next_s.ram[last] = pwdata_i[7:0]; // see R3
                     end else begin
                        next_s.ram[s.waddr] = pwdata_i[7:0]; // see R1
                     end
                     // Address advance is the same in both entry modes
                     if (s.auto_increment_flag) begin
                        next_s.waddr = (s.waddr + 4'h1) & mask; // see R4, see R2, see R6
                     end // see R5
                  end
               end else begin
                  if (s.count == 4'h0) begin
                     next_s.underrun = 1'b1; // see R11
                  end else begin
                     do_pop             = 1'b1;
                     next_s.prdata[7:0] = s.fifo[s.rd_ptr];
                  end
               end
            end
            DFS_REG_STATUS: begin
               if (!pwrite_i) begin
                  next_s.prdata[7:0] = status_w; // see R17
               end
            end
            DFS_REG_CMD: begin
               if (pwrite_i) begin
                  if (pwdata_i[DFS_CMD_CLR_DISP] | pwdata_i[DFS_CMD_CLR_ALL]) begin
                     next_s.ram      = {16{DFS_BLANK}};
                     next_s.clearing = 1'b1;         // see R12
                     next_s.clr_cnt  = DFS_CLEAR_CYC; // see R18
                  end
                  fclr = pwdata_i[DFS_CMD_CLR_FIFO] | pwdata_i[DFS_CMD_CLR_ALL];
               end
            end
            DFS_REG_PRESC: begin
               if (pwrite_i) begin
                  next_s.presc = pwdata_i[7:0];
               end else begin
                  next_s.prdata[7:0] = s.presc;
               end
            end
            default: begin
               next_s.pslverr = 1'b1; // Unmapped address
            end
         endcase
      end

      // FIFO clear drops contents and flags before new events are applied
      if (fclr) begin
         next_s.rd_ptr   = 3'h0;
         next_s.wr_ptr   = 3'h0;
         next_s.count    = 4'h0;
         next_s.overrun  = 1'b0;
         next_s.underrun = 1'b0;
         next_s.err_flag = 1'b0;
      end
      if (do_pop) begin
         next_s.rd_ptr = s.rd_ptr + 3'h1;
         next_s.count  = next_s.count - 4'h1;
      end

      // Key entry; a pop in the same cycle makes room
      if (key_valid_i) begin
         if (s.count == DFS_FIFO_FULL && !do_pop) begin
            next_s.overrun = 1'b1; // see R10
         end else if (!(s.spec_err && s.err_flag)) begin
            do_push                      = 1'b1;
            next_s.fifo[next_s.wr_ptr]   = key_code_i;
            next_s.wr_ptr                = next_s.wr_ptr + 3'h1;
            next_s.count                 = next_s.count + 4'h1;
         end
      end
      if (s.spec_err && multi_key_i) begin
         next_s.err_flag = 1'b1; // see R14
      end

      // Registered display drive
      next_s.digit = scan_digit;
      next_s.seg   = s.ram[scan_digit]; // see R1
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s       <= '0;
         s.presc <= DFS_PRESC_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign prdata_o  = s.prdata;
   assign pready_o  = s.pready;
   assign pslverr_o = s.pslverr;
   assign digit_o   = s.digit;
   assign seg_o     = s.seg;

   // Checks

   sequence wr_ok;
      data_wr && !s.clearing;
   endsequence
   sequence stat_read;
      acc && !pwrite_i && paddr_i == DFS_REG_STATUS;
   endsequence

   a_overrun_on_full: assert property ( // see R10
      key_valid_i && s.count == DFS_FIFO_FULL && !do_pop && !fclr
      |=> s.overrun && s.count == DFS_FIFO_FULL)
      else $error("overrun not flagged on full FIFO");
   a_underrun_on_empty: assert property ( // see R11
      acc && !pwrite_i && paddr_i == DFS_REG_DATA && s.count == 4'h0 |=> s.underrun ##1 s.underrun)
      else $error("underrun not flagged on empty read");
   a_clear_busy_span: assert property ( // see R18
      $rose(s.clearing) |-> s.clr_cnt == DFS_CLEAR_CYC ##1 s.clearing [*8])
      else $error("clear busy window too short");
   a_clear_self_end: assert property ( // see R18
      s.clearing && s.clr_cnt == 12'h001 && !(acc && pwrite_i && paddr_i == DFS_REG_CMD)
      |=> !s.clearing && status_w[DFS_ST_UNAV] == 1'b0)
      else $error("clear did not end");
   a_write_refused: assert property ( // see R18
      data_wr && s.clearing |=> s.ram == $past(s.ram) && s.pslverr)
      else $error("write accepted during clear");
   a_addr_advance: assert property ( // see R4
      wr_ok and s.auto_increment_flag |=> s.waddr == (($past(s.waddr) + 4'h1) & $past(mask)))
      else $error("auto-increment address wrong");
   a_addr_hold: assert property ( // see R5
      wr_ok and !s.auto_increment_flag |=> s.waddr == $past(s.waddr))
      else $error("address moved without auto-increment");
   a_right_lands: assert property ( // see R3
      wr_ok and s.right_entry |=> s.ram[$past(last)] == $past(pwdata_i[7:0]))
      else $error("right entry char not at rightmost");
   a_left_lands: assert property ( // see R1
      wr_ok and !s.right_entry |=> s.ram[$past(s.waddr)] == $past(pwdata_i[7:0]))
      else $error("left entry char not at address");
   a_status_word: assert property ( // see R17
      stat_read |=> s.pready && s.prdata[7:0] == $past(status_w))
      else $error("status word not returned");
   a_pready_pulse: assert property (
      s.pready |=> !s.pready)
      else $error("pready held more than one cycle");

   // FIFO bookkeeping: the count must follow every lone entry and every lone pop
   sequence entry_blocked;
      key_valid_i && s.spec_err && s.err_flag && !do_pop && !fclr;
   endsequence

   a_count_bounded: assert property ( // see R9
      s.count <= DFS_FIFO_FULL)
      else $error("FIFO count beyond capacity");
   a_push_counts: assert property ( // see R9
      do_push && !do_pop && !fclr |=> s.count == $past(s.count) + 4'h1)
      else $error("FIFO count did not follow entry");
   a_pop_counts: assert property ( // see R9
      do_pop && !do_push |=> s.count == $past(s.count) - 4'h1)
      else $error("FIFO count did not follow pop");

   // Special error mode: the flag latches and then blocks key entry into the FIFO
   a_error_flag_set: assert property ( // see R14
      s.spec_err && multi_key_i |=> s.err_flag)
      else $error("error flag not set on multi-key");
   a_error_blocks_entry: assert property ( // see R14
      entry_blocked |=> s.count == $past(s.count))
      else $error("entry accepted while error flag set");

   // Display RAM addressing and clearing
   a_left_wrap: assert property ( // see R2, see R20
      wr_ok and s.auto_increment_flag && s.waddr == mask |=> s.waddr == 4'h0)
      else $error("write address did not wrap");
   a_right_shift: assert property ( // see R3
      wr_ok and s.right_entry |=> s.ram[0] == $past(s.ram[1]))
      else $error("right entry did not shift left");
   a_clear_blanks: assert property ( // see R12
      acc && pwrite_i && paddr_i == DFS_REG_CMD && pwdata_i[DFS_CMD_CLR_DISP]
      |=> s.clearing && s.ram == {16{DFS_BLANK}})
      else $error("clear did not blank the display");

   // Anything outside the map is answered with an error and zero data
   a_unmapped_error: assert property (
      acc && paddr_i > DFS_REG_PRESC |=> s.pslverr && s.prdata == DFS_ZERO_WORD)
      else $error("unmapped access not refused");
endmodule // dfs_display_fifo

// [dfs_host.sv]
`timescale 1ns/1ps
// Bus host model: one APB transfer at a time, signals change only after a rising edge
module dfs_host (
   // Clock
   input  wire logic        sys_clk_i,
   // APB master side
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i
);
   // Idle bus at time zero
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0000_0000;
   end

   // Request held until pready is seen; released data shows the inverse, never a stale copy
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge sys_clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge sys_clk_i);
      penable_o <= 1'b1;
      do begin
         @(posedge sys_clk_i);
      end while (pready_i !== 1'b1);
      r = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o <= ~d;
   endtask
endmodule // dfs_host

// [testbench.sv]
`timescale 1ns/1ps
module testbench
   import dfs_pkg::*;
;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } dfs_row_t;

   logic        sys_clk_i = 1'b0;
   logic        nrst_i    = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        key_valid = 1'b0;
   logic [7:0]  key_code  = 8'h00;
   logic        multi_key = 1'b0;
   logic        sensor_closure = 1'b0;
   logic [3:0]  digit;
   logic [7:0]  seg;
   int          errors = 0;
   int          num_checks = 0;
   dfs_row_t    rows [12];

   // 25 MHz clock
   always #20 sys_clk_i = ~sys_clk_i;

   dfs_display_fifo dut (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .key_valid_i(key_valid),
      .key_code_i(key_code), .multi_key_i(multi_key), .sensor_closure_i(sensor_closure),
      .digit_o(digit), .seg_o(seg)
   );

   dfs_host host (
      .sys_clk_i(sys_clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
      .pslverr_i(pslverr)
   );

   // Compare tasks, one per result kind
   task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         errors++;
         $display("mismatch at %0t: word %h expected %h", $time, g, x);
      end
   endtask

   task automatic cmp_flag(input logic g, input logic x);
      num_checks++;
      if (g !== x) begin
         errors++;
         $display("mismatch at %0t: flag %b expected %b", $time, g, x);
      end
   endtask

   task automatic cmp_seg(input logic [7:0] g, input logic [7:0] x);
      num_checks++;
      if (g !== x) begin
         errors++;
         $display("mismatch at %0t: segment %h expected %h", $time, g, x);
      end
   endtask

   // One register access; read data is only compared on reads
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      host.xfer(w, a, d, r, e);
      if (!w) begin
         cmp_word(r, x);
      end
      cmp_flag(e, xe);
   endtask

   // Character write to display RAM
   task automatic put(input logic [7:0] c, input logic xe);
      acc(1'b1, DFS_REG_DATA, {24'h00_0000, c}, DFS_ZERO_WORD, xe);
   endtask

   // Present n characters on consecutive cycles
   task automatic keys(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk_i);
         key_valid <= 1'b1;
         key_code <= base + 8'(i);
      end
      @(posedge sys_clk_i);
      key_valid <= 1'b0;
   endtask

   // Wait for a fresh visit of digit d, then check its segment byte
   task automatic see_digit(input logic [3:0] d, input logic [7:0] x);
      int n;
      n = 0;
      while (digit === d && n < 3000) begin
         @(posedge sys_clk_i);
         n++;
      end
      while (digit !== d && n < 3000) begin
         @(posedge sys_clk_i);
         n++;
      end
      repeat (3) @(posedge sys_clk_i);
      cmp_flag(digit === d, 1'b1);
      cmp_seg(seg, x);
   endtask

   task automatic final_report;
      if (errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog, well above the expected 10k cycles
   initial begin
      repeat (80_000) @(posedge sys_clk_i);
      errors++;
      final_report();
   end

   // Main sequence
   initial begin
      rows[0]  = '{1'b0, DFS_REG_PRESC, DFS_ZERO_WORD, 32'h0000_00fa, 1'b0};
      rows[1]  = '{1'b1, DFS_REG_PRESC, 32'h0000_0001, DFS_ZERO_WORD, 1'b0};
      rows[2]  = '{1'b0, DFS_REG_PRESC, DFS_ZERO_WORD, 32'h0000_0001, 1'b0};
      rows[3]  = '{1'b1, DFS_REG_CTRL, 32'h0000_0006, DFS_ZERO_WORD, 1'b0};
      rows[4]  = '{1'b0, DFS_REG_CTRL, DFS_ZERO_WORD, 32'h0000_0006, 1'b0};
      rows[5]  = '{1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b0};
      rows[6]  = '{1'b0, DFS_REG_DATA, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b0};
      rows[7]  = '{1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, 32'h0000_0010, 1'b0};
      rows[8]  = '{1'b1, DFS_REG_STATUS, 32'h0000_00ff, DFS_ZERO_WORD, 1'b0};
      rows[9]  = '{1'b0, 8'h18, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b1};
      rows[10] = '{1'b1, DFS_REG_CMD, 32'h0000_0002, DFS_ZERO_WORD, 1'b0};
      rows[11] = '{1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b0};
      repeat (16) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      foreach (rows[i]) acc(rows[i].w, rows[i].a, rows[i].d, rows[i].x, rows[i].e);
      // Left entry, auto increment, wrap past the last of 16
      acc(1'b1, DFS_REG_ADDR, 32'h0000_000e, DFS_ZERO_WORD, 1'b0);
      put(8'h41, 1'b0);
      put(8'h42, 1'b0);
      put(8'h43, 1'b0);
      see_digit(4'he, 8'h41);
      see_digit(4'hf, 8'h42);
      see_digit(4'h0, 8'h43);
      // No auto increment: both writes land in one place
      acc(1'b1, DFS_REG_CTRL, 32'h0000_0002, DFS_ZERO_WORD, 1'b0);
      acc(1'b1, DFS_REG_ADDR, 32'h0000_0003, DFS_ZERO_WORD, 1'b0);
      put(8'h44, 1'b0);
      put(8'h45, 1'b0);
      see_digit(4'h3, 8'h45);
      see_digit(4'h4, 8'h00);
      // Eight digits: wrap at 7 and scan limited to 0..7
      acc(1'b1, DFS_REG_CTRL, 32'h0000_0004, DFS_ZERO_WORD, 1'b0);
      acc(1'b1, DFS_REG_ADDR, 32'h0000_0007, DFS_ZERO_WORD, 1'b0);
      put(8'h46, 1'b0);
      put(8'h47, 1'b0);
      see_digit(4'h7, 8'h46);
      see_digit(4'h0, 8'h47);
      repeat (600) begin
         @(posedge sys_clk_i);
         cmp_flag(digit[3], 1'b0);
      end
      // Clear display: busy bit, refused write, self-ending
      acc(1'b1, DFS_REG_CMD, 32'h0000_0001, DFS_ZERO_WORD, 1'b0);
      acc(1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, 32'h0000_0080, 1'b0);
      put(8'h55, 1'b1);
      repeat (4100) @(posedge sys_clk_i);
      acc(1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b0);
      see_digit(4'h3, 8'h00);
      // Right entry from address zero, sequential
      acc(1'b1, DFS_REG_CTRL, 32'h0000_0007, DFS_ZERO_WORD, 1'b0);
      acc(1'b1, DFS_REG_ADDR, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b0);
      put(8'h31, 1'b0);
      put(8'h32, 1'b0);
      put(8'h33, 1'b0);
      see_digit(4'hf, 8'h33);
      see_digit(4'he, 8'h32);
      see_digit(4'hd, 8'h31);
      see_digit(4'hc, 8'h00);
      // FIFO fill past full, pop, clear
      keys(9, 8'ha0);
      acc(1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, 32'h0000_0028, 1'b0);
      acc(1'b0, DFS_REG_DATA, DFS_ZERO_WORD, 32'h0000_00a0, 1'b0);
      acc(1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, 32'h0000_0027, 1'b0);
      acc(1'b1, DFS_REG_CMD, 32'h0000_0002, DFS_ZERO_WORD, 1'b0);
      acc(1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b0);
      // Sensor mode: closure shown while present, gone once released
      acc(1'b1, DFS_REG_CTRL, 32'h0000_0010, DFS_ZERO_WORD, 1'b0);
      sensor_closure <= 1'b1;
      acc(1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, 32'h0000_0040, 1'b0);
      sensor_closure <= 1'b0;
      acc(1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b0);
      // Special error: flag shown and further entry blocked
      acc(1'b1, DFS_REG_CTRL, 32'h0000_0008, DFS_ZERO_WORD, 1'b0);
      @(posedge sys_clk_i);
      multi_key <= 1'b1;
      @(posedge sys_clk_i);
      multi_key <= 1'b0;
      keys(1, 8'h11);
      acc(1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, 32'h0000_0040, 1'b0);
      acc(1'b1, DFS_REG_CMD, 32'h0000_0002, DFS_ZERO_WORD, 1'b0);
      acc(1'b0, DFS_REG_STATUS, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b0);
      // Second reset in mid-run restores defaults
      @(posedge sys_clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      cmp_flag(pready, 1'b0);
      cmp_word(prdata, DFS_ZERO_WORD);
      cmp_word({20'h0_0000, digit, seg}, DFS_ZERO_WORD);
      nrst_i <= 1'b1;
      acc(1'b0, DFS_REG_CTRL, DFS_ZERO_WORD, DFS_ZERO_WORD, 1'b0);
      acc(1'b0, DFS_REG_PRESC, DFS_ZERO_WORD, 32'h0000_00fa, 1'b0);
      final_report();
   end
endmodule // testbench
